// ### dps_pkg.sv
// Shared constants for the dual-port synchronous SRAM port logic.
// Assumes one system clock drives both ports and the array model.
package dps_pkg;

    // ****************************************************************
    // Organisation defaults
    // ****************************************************************
    localparam int NUM_PORTS     = 2;   // Left and right port.
    localparam int PORT_LEFT     = 0;
    localparam int PORT_RIGHT    = 1;
    localparam int DEF_ADDR_W    = 13;  // 8K words.
    localparam int DEF_DATA_W    = 18;  // x18 organisation.
    localparam int DEF_LOWER_W   = 9;   // Lower lane is bits 0 to 8.
    localparam int SYNC_STAGES   = 2;   // Flip-flops on every pin input.
    localparam int MEM_READ_LAT  = 1;   // Cycles from access to array data.
    localparam int PIPE_EXTRA    = 1;   // Extra cycles in pipelined mode.

    // ****************************************************************
    // Pin encodings and reset values
    // ****************************************************************
    localparam logic RW_WRITE      = 1'h0;  // Direction input low writes.
    localparam logic TIMING_FLOW   = 1'h0;  // Mode pin low: flow-through.
    localparam logic TIMING_PIPE   = 1'h1;  // Mode pin high: pipelined.
    localparam logic OE_N_RESET    = 1'h1;  // Data pins released at reset.
    localparam logic PDOWN_RESET   = 1'h1;  // Ports start powered down.

endpackage : dps_pkg

// ### dps_mem_if.sv
// Bundle between the port control logic and the shared storage array.
// Assumes both ends sit on the same clock; one slot per port.
`timescale 1ns/1ns
interface dps_mem_if #(
    parameter int ADDR_W = dps_pkg::DEF_ADDR_W,
    parameter int DATA_W = dps_pkg::DEF_DATA_W
);
    logic [dps_pkg::NUM_PORTS-1:0]             en;     // Access this cycle.
    logic [dps_pkg::NUM_PORTS-1:0]             we;     // Write when high.
    logic [dps_pkg::NUM_PORTS-1:0][ADDR_W-1:0] addr;   // Word address.
    logic [dps_pkg::NUM_PORTS-1:0][DATA_W-1:0] wmask;  // Bit write mask.
    logic [dps_pkg::NUM_PORTS-1:0][DATA_W-1:0] wdata;  // Write data.
    logic [dps_pkg::NUM_PORTS-1:0][DATA_W-1:0] rdata;  // Registered read data.

    modport ctrl  (output en, we, addr, wmask, wdata, input rdata);
    modport array (input en, we, addr, wmask, wdata, output rdata);
endinterface : dps_mem_if

// ### dps_array.sv
// Shared storage array with one access slot per port and registered reads.
// Assumes the control logic presents qualified accesses on the bundle.
`timescale 1ns/1ns
module dps_array #(
    parameter int ADDR_W = dps_pkg::DEF_ADDR_W,
    parameter int DATA_W = dps_pkg::DEF_DATA_W
) (
    input  wire logic clock_i,    // Array clock.
    input  wire logic reset_n_i,  // Asynchronous reset, clears read data.
    dps_mem_if.array  mem         // Access bundle from the ports.
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    localparam int DEPTH = 1 << ADDR_W;

    logic [DATA_W-1:0] words [DEPTH];

    typedef struct packed {
        logic [dps_pkg::NUM_PORTS-1:0][DATA_W-1:0] rdata;
    } dps_array_state_t;

    dps_array_state_t state;
    dps_array_state_t next_state;

    // Masked writes; the array itself needs no reset. When both ports
    // write one word in one cycle the right port's masked write wins.
    always_ff @(posedge clock_i) begin
        for (int p = 0; p < dps_pkg::NUM_PORTS; p++) begin
            if (mem.en[p] && mem.we[p]) begin
                words[mem.addr[p]] <= (words[mem.addr[p]] & ~mem.wmask[p])
                                    | (mem.wdata[p] & mem.wmask[p]);
            end
        end
    end

    // Read-before-write; either port reaches any word at any time.
    always_comb begin
        next_state = state;
        for (int p = 0; p < dps_pkg::NUM_PORTS; p++) begin
            if (mem.en[p]) begin
                next_state.rdata[p] = words[mem.addr[p]];
            end
        end
    end

    // State register.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign mem.rdata = state.rdata;

endmodule // dps_array

// ### dps_port_ctrl.sv
// Port control logic for a dual-port synchronous SRAM with burst counters.
// Assumes all pin inputs are synchronous to clock_i but still pass two
// flip-flops; the array module is instantiated here.
`timescale 1ns/1ns
module dps_port_ctrl #(
    parameter int ADDR_W  = dps_pkg::DEF_ADDR_W,
    parameter int DATA_W  = dps_pkg::DEF_DATA_W,
    parameter int LOWER_W = dps_pkg::DEF_LOWER_W
) (
    input  wire logic                                        clock_i,                   // Clock.
    input  wire logic                                        reset_n_i,                 // Async reset.
    input  wire logic [dps_pkg::NUM_PORTS-1:0][ADDR_W-1:0]   address_i,                 // Address pins.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               address_strobe_n_i,        // Strobe, low.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               chip_select_low_active_i,  // Select, low.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               chip_select_high_active_i, // Select, high.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               burst_count_enable_n_i,    // Count, low.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               burst_counter_clear_n_i,   // Clear, low.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               lower_lane_select_n_i,     // Lower lane, low.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               upper_lane_select_n_i,     // Upper lane, low.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               output_enable_n_i,         // Output enable, low.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               read_write_i,              // High read, low write.
    input  wire logic [dps_pkg::NUM_PORTS-1:0]               output_timing_select_i,    // Low flow, high pipe.
    input  wire logic [dps_pkg::NUM_PORTS-1:0][DATA_W-1:0]   data_i,                    // Data pins in.
    output logic      [dps_pkg::NUM_PORTS-1:0][DATA_W-1:0]   data_o,                    // Data pins out.
    output logic      [dps_pkg::NUM_PORTS-1:0][DATA_W-1:0]   data_oe_n_o,               // Drive when low.
    output logic      [dps_pkg::NUM_PORTS-1:0][ADDR_W-1:0]   burst_address_o,           // Counter value.
    output logic      [dps_pkg::NUM_PORTS-1:0]               power_down_o               // Port powered down.
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (LOWER_W < 1 || LOWER_W >= DATA_W) begin : g_bad_lane
        $error("Lower lane width must leave room for an upper lane.");
    end
    if (ADDR_W < 1 || ADDR_W > DATA_W) begin : g_bad_addr
        $error("Counter load from data pins needs ADDR_W not above DATA_W.");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic              ads_n;
        logic              cs_lo_n;
        logic              cs_hi;
        logic              cnt_n;
        logic              clr_n;
        logic              lo_n;
        logic              hi_n;
        logic              oe_n;
        logic              rw;
        logic              timing;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] din;
    } dps_pins_t;

    typedef struct packed {
        dps_pins_t         s1;       // First synchroniser stage.
        dps_pins_t         s2;       // Second stage, the only one read.
        logic [ADDR_W-1:0] counter;  // Burst address counter.
        logic              pdown;    // Deselected in the last cycle.
        logic              rd_v;     // Read issued, array data now valid.
        logic              rd_lo;
        logic              rd_hi;
        logic              rd_warm;  // Port was selected before the read.
        logic              pp_v;     // Pipeline output stage.
        logic              pp_lo;
        logic              pp_hi;
        logic [DATA_W-1:0] pp_data;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] oe_n;
    } dps_port_t;

    typedef struct packed {
        dps_port_t [dps_pkg::NUM_PORTS-1:0] port;
    } dps_state_t;

    dps_state_t state;
    dps_state_t next_state;

    dps_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mem ();

    // Expands two lane enables into a per-bit mask.
    function automatic logic [DATA_W-1:0] lane_mask(input logic lo, input logic hi);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int b = 0; b < DATA_W; b++) begin
            m[b] = (b < LOWER_W) ? lo : hi;
        end
        return m;
    endfunction

    // ****************************************************************
    // Port logic
    // ****************************************************************
    // Every decision uses the second sync stage and registered history
    // only, so a sampled pin acts two edges later: the clock must keep
    // running after each transaction for it to take effect.
    always_comb begin
        logic              sel;
        logic              rd;
        logic              src_v;
        logic              src_lo;
        logic              src_hi;
        logic [DATA_W-1:0] src_data;
        dps_pins_t         s;
        dps_port_t         p;
        sel        = 1'h0;
        rd         = 1'h0;
        src_v      = 1'h0;
        src_lo     = 1'h0;
        src_hi     = 1'h0;
        src_data   = '0;
        s          = '0;
        p          = '0;
        next_state = state;
        mem.en     = '0;
        mem.we     = '0;
        mem.addr   = '0;
        mem.wmask  = '0;
        mem.wdata  = '0;
        for (int i = 0; i < dps_pkg::NUM_PORTS; i++) begin
            p = state.port[i];
            s = p.s2;

            // Pin capture; stage one feeds only stage two.
            next_state.port[i].s1.ads_n   = address_strobe_n_i[i];
            next_state.port[i].s1.cs_lo_n = chip_select_low_active_i[i];
            next_state.port[i].s1.cs_hi   = chip_select_high_active_i[i];
            next_state.port[i].s1.cnt_n   = burst_count_enable_n_i[i];
            next_state.port[i].s1.clr_n   = burst_counter_clear_n_i[i];
            next_state.port[i].s1.lo_n    = lower_lane_select_n_i[i];
            next_state.port[i].s1.hi_n    = upper_lane_select_n_i[i];
            next_state.port[i].s1.oe_n    = output_enable_n_i[i];
            next_state.port[i].s1.rw     = read_write_i[i];
            next_state.port[i].s1.timing  = output_timing_select_i[i];
            next_state.port[i].s1.addr    = address_i[i];
            next_state.port[i].s1.din     = data_i[i];
            next_state.port[i].s2         = p.s1;

            // Both selects must be active together.
            sel = !s.cs_lo_n && s.cs_hi;

            // Counter priority: clear, then strobe load, then count.
            if (!s.clr_n) begin
                next_state.port[i].counter = '0;
            end else if (!s.ads_n) begin
                next_state.port[i].counter = s.din[ADDR_W-1:0];
            end else if (!s.cnt_n) begin
                // Natural overflow of the full-width counter wraps to zero.
                next_state.port[i].counter = p.counter + ADDR_W'(1);
            end

            // A strobed cycle uses the address pins, otherwise the counter.
            mem.en[i]    = sel;
            mem.addr[i]  = !s.ads_n ? s.addr : p.counter;
            mem.we[i]    = sel && (s.rw == dps_pkg::RW_WRITE);
            mem.wmask[i] = lane_mask(!s.lo_n, !s.hi_n);
            mem.wdata[i] = s.din;
            rd           = sel && (s.rw != dps_pkg::RW_WRITE);

            // A single deselected cycle powers the port down.
            next_state.port[i].pdown   = !sel;
            next_state.port[i].rd_v    = rd;
            next_state.port[i].rd_lo   = !s.lo_n;
            next_state.port[i].rd_hi   = !s.hi_n;
            next_state.port[i].rd_warm = !p.pdown;

            // Extra register stage for pipelined timing; a read issued in
            // the first selected cycle after power-down is dropped in pipelined mode only.
            next_state.port[i].pp_v    = p.rd_v && p.rd_warm;
            next_state.port[i].pp_lo   = p.rd_lo;
            next_state.port[i].pp_hi   = p.rd_hi;
            next_state.port[i].pp_data = mem.rdata[i];

            // Mode pin picks the source of the output register.
            if (s.timing == dps_pkg::TIMING_PIPE) begin
                src_v    = p.pp_v;
                src_lo   = p.pp_lo;
                src_hi   = p.pp_hi;
                src_data = p.pp_data;
            end else begin
                src_v    = p.rd_v;
                src_lo   = p.rd_lo;
                src_hi   = p.rd_hi;
                src_data = mem.rdata[i];
            end

            // Lanes drive only with their select and the output enable.
            next_state.port[i].dout = src_data;
            next_state.port[i].oe_n = ~lane_mask(src_v && src_lo && !s.oe_n,
                                                 src_v && src_hi && !s.oe_n);
        end
    end

    // State register; synchroniser stages reset to a deselected pattern.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= '0;
            for (int i = 0; i < dps_pkg::NUM_PORTS; i++) begin
                state.port[i].oe_n  <= {DATA_W{dps_pkg::OE_N_RESET}};
                state.port[i].pdown <= dps_pkg::PDOWN_RESET;
            end
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs and array
    // ****************************************************************
    // Every output is a state flip-flop with no gate in between.
    always_comb begin
        for (int i = 0; i < dps_pkg::NUM_PORTS; i++) begin
            data_o[i]          = state.port[i].dout;
            data_oe_n_o[i]     = state.port[i].oe_n;
            burst_address_o[i] = state.port[i].counter;
            power_down_o[i]    = state.port[i].pdown;
        end
    end

    dps_array #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_array (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .mem       (mem.array)
    );

endmodule // dps_port_ctrl

// ### dps_port_chk.sv
// Checker for the SRAM port logic: counter controls, selection and pin drive.
// Assumes every pin passes two flip-flops, so a sampled cycle acts two edges later.
`timescale 1ns/1ns
module dps_port_chk #(
    parameter int ADDR_W  = dps_pkg::DEF_ADDR_W,  // Counter width.
    parameter int DATA_W  = dps_pkg::DEF_DATA_W,  // Word width.
    parameter int LOWER_W = dps_pkg::DEF_LOWER_W  // Lower lane width.
) (
    input wire logic                   clock_i,                   // Clock.
    input wire logic                   reset_n_i,                 // Reset, low.
    input wire logic [1:0]             address_strobe_n_i,        // Strobe.
    input wire logic [1:0]             chip_select_low_active_i,  // Select, low.
    input wire logic [1:0]             chip_select_high_active_i, // Select, high.
    input wire logic [1:0]             burst_count_enable_n_i,    // Count.
    input wire logic [1:0]             burst_counter_clear_n_i,   // Clear.
    input wire logic [1:0]             lower_lane_select_n_i,     // Lower lane.
    input wire logic [1:0]             output_enable_n_i,         // Output enable.
    input wire logic [1:0]             read_write_i,              // Direction.
    input wire logic [1:0]             output_timing_select_i,    // Mode.
    input wire logic [1:0][DATA_W-1:0] data_i,                    // Load source.
    input wire logic [1:0][DATA_W-1:0] data_oe_n_o,               // Drive enables.
    input wire logic [1:0][ADDR_W-1:0] burst_address_o,           // Counter.
    input wire logic [1:0]             power_down_o               // Powered down.
);
    wire  [1:0] sel = ~chip_select_low_active_i & chip_select_high_active_i;  // Port selected.
    wire  [1:0] rd  = sel & read_write_i;                                     // Selected read.
    logic [3:0] up_cnt;                                                       // Edges since reset.

    // Checks wait until the deepest look-back sees only post-reset samples.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_cnt <= 4'h0;
        end else if (!up_cnt[3]) begin
            up_cnt <= up_cnt + 4'h1;
        end
    end

    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    for (genvar p = 0; p < 2; p++) begin : g_port
        chk_clear_wins:
        assert property (up_cnt[3] && $past(sel[p] && !burst_counter_clear_n_i[p], 3) |-> burst_address_o[p] == '0)
            else $error("Counter clear lost.");
        chk_strobe_loads:
        assert property (up_cnt[3] && $past(sel[p] && !address_strobe_n_i[p] && burst_counter_clear_n_i[p], 3)
            |-> burst_address_o[p] == $past(data_i[p][ADDR_W-1:0], 3)) else $error("Counter load wrong.");
        chk_count_step:
        assert property (up_cnt[3] && $past(sel[p] && address_strobe_n_i[p] && burst_counter_clear_n_i[p]
            && !burst_count_enable_n_i[p], 3) |-> burst_address_o[p] == ADDR_W'($past(burst_address_o[p]) + 1))
            else $error("Counter step wrong.");
        chk_power_down:
        assert property (up_cnt[3] |-> power_down_o[p] == $past(!sel[p], 3)) else $error("Power-down wrong.");
        chk_oe_gate:
        assert property (up_cnt[3] && $past(output_enable_n_i[p], 3) |-> &data_oe_n_o[p])
            else $error("Pins driven with output enable high.");
        chk_lower_gate:
        assert property (up_cnt[3] && !(&data_oe_n_o[p][LOWER_W-1:0]) |->
            $past(rd[p] && !lower_lane_select_n_i[p] && !output_timing_select_i[p], 4)
            || $past(rd[p] && !lower_lane_select_n_i[p] && output_timing_select_i[p], 5))
            else $error("Lower lane driven without a read.");
        chk_flow_drive:
        assert property (up_cnt[3] && $past(rd[p] && !lower_lane_select_n_i[p] && !output_timing_select_i[p], 4)
            && !$past(output_enable_n_i[p], 3) |-> data_oe_n_o[p][LOWER_W-1:0] == '0)
            else $error("Flow-through read not driven.");
        chk_pipe_drive:
        assert property (up_cnt[3] && $past(sel[p], 6) && !$past(output_enable_n_i[p], 3)
            && $past(rd[p] && !lower_lane_select_n_i[p] && output_timing_select_i[p], 5)
            |-> data_oe_n_o[p][LOWER_W-1:0] == '0) else $error("Pipelined read not driven.");
    end
endmodule // dps_port_chk

bind dps_port_ctrl dps_port_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LOWER_W(LOWER_W)) i_chk (.*);

// ### dps_master.sv
// Bus master model driving the pins of both SRAM ports.
// Assumes one rising-edge clock; each call of cyc spans one cycle.
`timescale 1ns/1ns
module dps_master (
    input  wire logic  clock_i,                   // Clock.
    output logic [1:0] chip_select_low_active_o,  // Select, low.
    output logic [1:0] chip_select_high_active_o, // Select, high.
    output logic [1:0] address_strobe_n_o,        // Strobe.
    output logic [1:0] burst_count_enable_n_o,    // Count.
    output logic [1:0] burst_counter_clear_n_o,   // Clear.
    output logic [1:0] lower_lane_select_n_o,     // Lower lane.
    output logic [1:0] upper_lane_select_n_o,     // Upper lane.
    output logic [1:0] output_enable_n_o,         // Output enable.
    output logic [1:0] read_write_o,              // Direction.
    output logic [1:0] output_timing_select_o,    // Mode.
    output logic [1:0][12:0] address_o,           // Address pins.
    output logic [1:0][17:0] data_o               // Data pins.
);
    // Drive one port; a bus the master has let go shows the inverse of its last value.
    task automatic put(input int q, input logic [7:0] k, input logic [12:0] a, input logic [17:0] d);
        {chip_select_high_active_o[q], read_write_o[q], address_strobe_n_o[q], burst_count_enable_n_o[q],
         burst_counter_clear_n_o[q], lower_lane_select_n_o[q], upper_lane_select_n_o[q], output_enable_n_o[q]} = k;
        chip_select_low_active_o[q] = !k[7];
        address_o[q] = k[7] ? a : ~address_o[q];
        data_o[q] = (k[7] && !k[6]) ? d : ~data_o[q];
    endtask

    // 1 ns after the edge: port p gets code c, the other port is parked deselected.
    task automatic cyc(input int p, input logic [7:0] c, input logic [12:0] a, input logic [17:0] d);
        @(posedge clock_i);
        #1;
        for (int q = 0; q < 2; q++) begin
            put(q, (q == p) ? c : 8'h7F, a, d);
        end
    endtask

    task automatic set_mode(input int p, input logic m);
        output_timing_select_o[p] = m;
    endtask

    // Both ports start parked so no access is made during reset.
    initial begin
        address_o = '0;
        data_o = '0;
        output_timing_select_o = 2'h0;
        put(0, 8'h7F, 13'h0000, 18'h00000);
        put(1, 8'h7F, 13'h0000, 18'h00000);
    end
endmodule // dps_master

// ### dual_port_sync_sram_port_tb_top.sv
// Self-checking bench: lane writes and reads across ports, burst counter controls.
// Assumes the master model drives the pins and the checker is bound to the design.
`timescale 1ns/1ns
module dual_port_sync_sram_port_tb_top;
    logic             clock_i = 1'b0;   // 10 MHz clock.
    logic             reset_n_i = 1'b0; // Reset, low.
    wire  [1:0]       chip_select_low_active_i, chip_select_high_active_i, address_strobe_n_i;
    wire  [1:0]       burst_count_enable_n_i, burst_counter_clear_n_i, lower_lane_select_n_i;
    wire  [1:0]       upper_lane_select_n_i, output_enable_n_i, read_write_i, output_timing_select_i, power_down_o;
    wire  [1:0][12:0] address_i, burst_address_o;
    wire  [1:0][17:0] data_i, data_o, data_oe_n_o;
    int               num_errors = 0;
    int               tests_run = 0;
    logic [31:0]      seed = 32'h99DE2997;

    always #50 clock_i = ~clock_i;

    dps_port_ctrl i_dut (.*);
    dps_master i_master (.clock_i(clock_i), .chip_select_low_active_o(chip_select_low_active_i),
        .chip_select_high_active_o(chip_select_high_active_i), .address_strobe_n_o(address_strobe_n_i),
        .burst_count_enable_n_o(burst_count_enable_n_i), .burst_counter_clear_n_o(burst_counter_clear_n_i),
        .lower_lane_select_n_o(lower_lane_select_n_i), .upper_lane_select_n_o(upper_lane_select_n_i),
        .output_enable_n_o(output_enable_n_i), .read_write_o(read_write_i), .address_o(address_i),
        .output_timing_select_o(output_timing_select_i), .data_o(data_i));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // A low lane select lets that lane take the new bits; the other keeps its old ones.
    function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] n, logic lb_n, logic ub_n);
        logic [17:0] m;
        m = {{9{!ub_n}}, {9{!lb_n}}};
        return (n & m) | (o & ~m);
    endfunction

    task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) i_master.cyc(0, 8'h7F, 13'h0000, 18'h00000);
    endtask

    // A counter operation acts two edges after sampling, so look three cycles on.
    task automatic ctr(input int p, input logic [7:0] c, input logic [17:0] d, input logic [12:0] e);
        i_master.cyc(p, c, 13'h0000, d);
        idle(3);
        check(18'(burst_address_o[p]), 18'(e), "counter");
        check(18'(power_down_o[p]), 18'(!c[7]), "power-down");
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence: lane writes and cross-port reads, then counter control per port.
    initial begin
        repeat (6) @(posedge clock_i);
        #1;
        reset_n_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            logic [31:0] r;
            logic [17:0] d0;
            logic [17:0] m;
            logic [7:0]  rc;
            int          q;
            q = 1 - (i % 2);
            r = rnd();
            d0 = r[17:0];
            r = rnd();
            rc = {5'h1B, r[15], r[16], r[19:17] == 3'h0};
            m = rc[0] ? 18'h3FFFF : {{9{rc[1]}}, {9{rc[2]}}};
            idle(6);
            i_master.set_mode(q, i[1]);
            i_master.cyc(1 - q, 8'h99, r[12:0], d0);
            i_master.cyc(1 - q, {5'h13, r[13], r[14], 1'h1}, r[12:0], r[31:14]);
            repeat (6 + int'(i[1])) i_master.cyc(q, rc, r[12:0], 18'h00000);
            check(data_oe_n_o[q], m, "lane enables");
            check(data_o[q] | m, merge(d0, r[31:14], r[13], r[14]) | m, "read data");
        end
        $display("Lane write and read test done");
        for (int p = 0; p < 2; p++) begin
            logic [31:0] r;
            int          n;
            r = rnd();
            n = int'(r[14:13]) + 1;
            idle(6);
            ctr(p, 8'h9F, 18'h01FFF, 13'h1FFF);
            ctr(p, 8'hEF, 18'h00000, 13'h0000);
            ctr(p, 8'h8F, {5'h00, r[12:0]}, r[12:0]);
            repeat (n - 1) i_master.cyc(p, 8'hEF, 13'h0000, 18'h00000);
            ctr(p, 8'hEF, 18'h00000, r[12:0] + 13'(n));
            // The counter keeps counting while the port is deselected.
            ctr(p, 8'h6F, 18'h00000, r[12:0] + 13'(n + 1));
            ctr(p, 8'h87, {5'h00, ~r[12:0]}, 13'h0000);
        end
        $display("Burst counter test done");
        report_and_stop();
    end

    // Guard against a hung run.
    initial begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        report_and_stop();
    end
endmodule // dual_port_sync_sram_port_tb_top
